// file: hdl/switch_guard_pkg.sv
// Purpose: constants and types for the power switch protection block
// Assumes: 100 MHz ref_clk
// Notes:   times in ns, cycle counts derived
`default_nettype none
package switch_guard_pkg;
    localparam int CLK_PERIOD_NS       = 10;
    // overcurrent trip delay and qualification window
    localparam int OC_TRIP_DELAY_NS    = 50;
    localparam int OC_TRIP_CYC         =
        (OC_TRIP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OC_WINDOW_NS        = 30;
    localparam int OC_WINDOW_CYC       =
        (OC_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // short-circuit latch reset: continuous low time on cmd
    localparam int SC_RESET_NS         = 400000;
    localparam int SC_RESET_CYC        = SC_RESET_NS / CLK_PERIOD_NS;
    // cmd period below this is the higher frequency range
    localparam int FREQ_SPLIT_NS       = 2000;
    localparam int FREQ_SPLIT_CYC      = FREQ_SPLIT_NS / CLK_PERIOD_NS;
    localparam int HIGH_FREQ_RUN       = 5;
    localparam int CNT_W               = 16;
    localparam int RUN_W               = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [RUN_W-1:0] RUN_ZERO = 3'h0;

    typedef enum logic [1:0] {
        CONV_IDLE    = 2'b00,
        CONV_ENERGISE = 2'b01,
        CONV_DISCHARGE = 2'b10
    } conv_state_e;
endpackage
`default_nettype wire

// file: hdl/inverter_ctrl_if.sv
// Purpose: link between guard core and negative-rail converter control
// Assumes: single clock
// Notes:   peak_high_sel picks the higher peak limit
`default_nettype none
interface inverter_ctrl_if;
    logic peak_high_sel;
    logic peak_reached;
    logic inductor_zero;
    logic rail_low;
    logic switch_on;
    logic peak_high_out;
    modport core (output peak_high_sel, output peak_reached,
                  output inductor_zero, output rail_low,
                  input switch_on, input peak_high_out);
    modport conv (input peak_high_sel, input peak_reached,
                  input inductor_zero, input rail_low,
                  output switch_on, output peak_high_out);
endinterface
`default_nettype wire

// file: hdl/inverter_ctrl.sv
// Purpose: hysteretic peak-current control of the negative-rail converter
// Assumes: comparator inputs synchronous to ref_clk
// Notes:   idle gap set by rail demand, may be zero
`default_nettype none
module inverter_ctrl
    import switch_guard_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    inverter_ctrl_if.conv   ctl
);
    typedef struct packed {
        conv_state_e st;
        logic        sw;
        logic        peak_hi;
    } conv_s;

    conv_s state_reg;
    conv_s state_next;

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next         = state_reg;
        state_next.peak_hi = ctl.peak_high_sel;
        case (state_reg.st)
            CONV_IDLE:
            begin
                // pulse starts as soon as rail needs charge
                if (ctl.rail_low) //RULE11
                begin
                    state_next.st = CONV_ENERGISE;
                    state_next.sw = 1'b1;
                end
            end
            CONV_ENERGISE:
            begin
                if (ctl.peak_reached) //RULE10
                begin
                    state_next.st = CONV_DISCHARGE;
                    state_next.sw = 1'b0;
                end
            end
            CONV_DISCHARGE:
            begin
                if (ctl.inductor_zero) //RULE10
                begin
                    // zero idle gap: next pulse back to back
                    state_next.st = ctl.rail_low ? CONV_ENERGISE
                                                 : CONV_IDLE; //RULE11
                    state_next.sw = ctl.rail_low;
                end
            end
            default:
            begin
                state_next.st = CONV_IDLE;
                state_next.sw = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_reg.st      <= CONV_IDLE;
            state_reg.sw      <= 1'b0;
            state_reg.peak_hi <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign ctl.switch_on     = state_reg.sw;
    assign ctl.peak_high_out = state_reg.peak_hi;

    ////////////////////////////////////////////////////////////////////
    a_conv_stop_peak: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg.sw && ctl.peak_reached && state_reg.st == CONV_ENERGISE
        |=> !state_reg.sw) //RULE10
        else $error("converter kept energising past peak");
endmodule
`default_nettype wire

// file: hdl/switch_guard.sv
// Purpose: overcurrent and short-circuit supervision of the power switch
// Assumes: comparator and command inputs synchronous to ref_clk
// Notes:   slow_off selects reduced turn-off drive after a short
`default_nettype none
// Operation
// RULE1 - overcurrent: after trip delay, switch off, alert low
// RULE2 - overcurrent clears when command goes low
// RULE3 - delayed overcurrent versus short comparator decides
// RULE4 - short circuit turns off with reduced drive
// RULE5 - short latched until long low or power-off
// RULE6 - classify command frequency into low/high range
// RULE7 - converter starts with low peak limit
// RULE8 - five consecutive high cycles select high limit
// RULE9 - high limit held until power removed
// RULE10 - converter energises to peak, then discharges fully
// RULE11 - idle gap automatic, can be zero
// RULE12 - alert high normally, low when not ready/fault
// RULE13 - overcurrent alert released on next command high
// RULE14 - short alert stays low until latch reset
// RULE15 - low-time counter restarts on command high
module switch_guard
    import switch_guard_pkg::*;
#(
    parameter int SC_RESET_CYCLES = SC_RESET_CYC
)
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic switch_cmd,
    input  wire logic ready,
    input  wire logic oc_comp,
    input  wire logic sc_comp,
    input  wire logic conv_peak_reached,
    input  wire logic conv_inductor_zero,
    input  wire logic conv_rail_low,
    output var  logic gate_on,
    output var  logic slow_off,
    output var  logic alert_n,
    output var  logic conv_switch_on,
    output var  logic conv_peak_high
);
    typedef struct packed {
        logic [CNT_W-1:0] oc_cnt;
        logic [CNT_W-1:0] win_cnt;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] per_cnt;
        logic [RUN_W-1:0] hi_run;
        logic             oc_trip;
        logic             oc_alert;
        logic             sc_latch;
        logic             peak_high;
        logic             cmd_d;
        logic             gate;
        logic             slow;
        logic             alert;
    } guard_s;

    guard_s state_reg;
    guard_s state_next;

    inverter_ctrl_if conv_if ();

    logic             cmd_rise;
    logic             oc_delayed;

    assign cmd_rise   = switch_cmd && !state_reg.cmd_d;
    assign oc_delayed = (state_reg.win_cnt >= CNT_W'(OC_WINDOW_CYC));

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next       = state_reg;
        state_next.cmd_d = switch_cmd;

        // overcurrent qualification window and trip delay
        if (oc_comp && switch_cmd)
        begin
            if (state_reg.win_cnt != 16'hFFFF)
                state_next.win_cnt = state_reg.win_cnt + 16'h0001;
            if (state_reg.oc_cnt != 16'hFFFF)
                state_next.oc_cnt = state_reg.oc_cnt + 16'h0001;
        end
        else
        begin
            state_next.win_cnt = CNT_ZERO;
            state_next.oc_cnt  = CNT_ZERO;
        end

        // short detected only if it beats the delayed overcurrent
        if (sc_comp && switch_cmd && !oc_delayed && !state_reg.oc_trip)
            state_next.sc_latch = 1'b1; //RULE3
        if (oc_delayed
            && state_reg.oc_cnt + 16'h0001 >= CNT_W'(OC_TRIP_CYC))
        begin
            state_next.oc_trip  = 1'b1; //RULE1
            state_next.oc_alert = 1'b1; //RULE1
        end
        if (!switch_cmd)
            state_next.oc_trip = 1'b0; //RULE2
        if (cmd_rise)
            state_next.oc_alert = 1'b0; //RULE13

        // latch reset by continuous low command
        if (switch_cmd)
            state_next.low_cnt = CNT_ZERO; //RULE15
        else if (state_reg.low_cnt != CNT_W'(SC_RESET_CYCLES))
            state_next.low_cnt = state_reg.low_cnt + 16'h0001; //RULE15
        else
            state_next.sc_latch = 1'b0; //RULE5

        // frequency classification on command rising edges
        if (cmd_rise)
        begin
            state_next.per_cnt = CNT_ZERO;
            if (state_reg.per_cnt < CNT_W'(FREQ_SPLIT_CYC)) //RULE6
            begin
                if (state_reg.hi_run == RUN_W'(HIGH_FREQ_RUN - 1))
                    state_next.peak_high = 1'b1; //RULE8
                else
                    state_next.hi_run = state_reg.hi_run + 3'h1;
            end
            else
                state_next.hi_run = RUN_ZERO; //RULE8
        end
        else if (state_reg.per_cnt != 16'hFFFF)
            state_next.per_cnt = state_reg.per_cnt + 16'h0001;

        state_next.gate  = switch_cmd && ready
                           && !state_next.oc_trip
                           && !state_next.sc_latch; //RULE1
        state_next.slow  = state_next.sc_latch; //RULE4
        state_next.alert = ready && !state_next.oc_alert //RULE12
                           && !state_next.sc_latch; //RULE14
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_reg           <= '0;
            // no rise seen yet: first rise must not count as fast
            state_reg.per_cnt   <= 16'hFFFF; //RULE6
            state_reg.peak_high <= 1'b0; //RULE7
        end
        else
        begin
            state_reg           <= state_next;
            state_reg.peak_high <= state_next.peak_high
                                   | state_reg.peak_high; //RULE9
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign conv_if.peak_high_sel = state_reg.peak_high;
    assign conv_if.peak_reached  = conv_peak_reached;
    assign conv_if.inductor_zero = conv_inductor_zero;
    assign conv_if.rail_low      = conv_rail_low;

    inverter_ctrl u_conv (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ctl     (conv_if)
    );

    assign gate_on        = state_reg.gate;
    assign slow_off       = state_reg.slow;
    assign alert_n        = state_reg.alert;
    assign conv_switch_on = conv_if.switch_on;
    assign conv_peak_high = conv_if.peak_high_out;

    ////////////////////////////////////////////////////////////////////
    a_oc_gate_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg.oc_trip |-> !gate_on) //RULE1
        else $error("gate on while overcurrent tripped");
    a_oc_clears_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !switch_cmd |=> !state_reg.oc_trip) //RULE2
        else $error("overcurrent not cleared by low command");
    a_sc_slow_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg.sc_latch |-> slow_off && !gate_on) //RULE4
        else $error("short latched without slow turn-off");
    a_sc_holds_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg.sc_latch && switch_cmd |=> state_reg.sc_latch) //RULE5
        else $error("short latch dropped while command high");
    a_peak_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg.peak_high |=> state_reg.peak_high) //RULE9
        else $error("high peak limit dropped");
    a_alert_sc_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg.sc_latch |-> !alert_n) //RULE14
        else $error("alert high during short latch");
    a_alert_oc_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(state_reg.oc_trip) |-> !alert_n) //RULE13
        else $error("alert high at overcurrent trip");
    a_alert_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(ready) |-> !alert_n) //RULE12
        else $error("alert high while not ready");
    a_low_cnt_rst: assert property (@(posedge ref_clk) disable iff (!rst_n)
        switch_cmd |=> state_reg.low_cnt == CNT_ZERO) //RULE15
        else $error("low-time counter not restarted");
    a_peak_start_low: assert property (@(posedge ref_clk)
        !rst_n |=> !state_reg.peak_high) //RULE7
        else $error("high peak limit after reset");
    a_peak_needs_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(state_reg.peak_high) |-> $past(cmd_rise)
        && $past(state_reg.hi_run) == 3'h4) //RULE8
        else $error("high limit without five fast cycles");
endmodule
`default_nettype wire

// file: testbench/pwm_source.sv
// Purpose: model of the external PWM controller driving switch_cmd
// Assumes: one clock, ref_clk
// Notes:   free-running PWM while run is high, else holds level
`default_nettype none
module pwm_source
(
    input  wire logic        ref_clk,
    input  wire logic        run,
    input  wire logic [15:0] period,
    input  wire logic [15:0] on_len,
    input  wire logic        level,
    output var  logic        switch_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt_reg;
    initial switch_cmd = 1'h0;
    always @(posedge ref_clk)
    begin
        if (run)
        begin
            cnt_reg <= (cnt_reg + 16'h0001 >= period) ? 16'h0000
                                                       : cnt_reg + 16'h0001;
            switch_cmd <= (cnt_reg < on_len);
        end
        else
        begin
            cnt_reg <= 16'h0000;
            switch_cmd <= level;
        end
    end
endmodule
`default_nettype wire

// file: testbench/tb_switch_guard.sv
// Purpose: self-checking bench for switch_guard
// Assumes: 100 MHz ref_clk, short latch reset shortened to 50 cycles
// Notes:   inputs driven by non-blocking assignment at rising edges
`default_nettype none
module tb_switch_guard;
    timeunit 1ns;
    timeprecision 1ns;
    import switch_guard_pkg::*;
    localparam int SC_CYC = 50;
    logic        ref_clk = 1'h0;
    logic        rst_n   = 1'h0;
    logic        ready   = 1'h0;
    logic        oc_comp = 1'h0;
    logic        sc_comp = 1'h0;
    logic        peak    = 1'h0;
    logic        zero    = 1'h0;
    logic        rail    = 1'h0;
    logic        run     = 1'h0;
    logic        level   = 1'h0;
    logic [15:0] period  = 16'h0064;
    logic        switch_cmd;
    logic        gate_on;
    logic        slow_off;
    logic        alert_n;
    logic        conv_on;
    logic        conv_high;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #5 ref_clk = ~ref_clk;

    pwm_source u_pwm (.ref_clk(ref_clk), .run(run), .period(period),
        .on_len(period >> 1), .level(level), .switch_cmd(switch_cmd));

    switch_guard #(.SC_RESET_CYCLES(SC_CYC)) dut (.ref_clk(ref_clk),
        .rst_n(rst_n), .switch_cmd(switch_cmd), .ready(ready),
        .oc_comp(oc_comp), .sc_comp(sc_comp), .conv_peak_reached(peak),
        .conv_inductor_zero(zero), .conv_rail_low(rail),
        .gate_on(gate_on), .slow_off(slow_off), .alert_n(alert_n),
        .conv_switch_on(conv_on), .conv_peak_high(conv_high));

    ////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        #1;
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic set_in(input logic lv, input logic oc, input logic sc);
        level <= lv;
        oc_comp <= oc;
        sc_comp <= sc;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic t_ready();
        tick(1);
        set_in(1'h1, 1'h0, 1'h0);
        tick(3);
        chk(alert_n, 1'h0);
        chk(gate_on, 1'h0);
        tick(1);
        ready <= 1'h1;
        tick(3);
        chk(alert_n, 1'h1);
        chk(gate_on, 1'h1);
        $display("test ready done");
    endtask

    task automatic t_overcurrent();
        tick(1);
        set_in(1'h1, 1'h1, 1'h0);
        tick(2);
        chk(gate_on, 1'h1);
        tick(2);
        // short comparator trips after the delayed overcurrent
        set_in(1'h1, 1'h1, 1'h1);
        tick(OC_TRIP_CYC + OC_WINDOW_CYC);
        chk(gate_on, 1'h0);
        chk(alert_n, 1'h0);
        chk(slow_off, 1'h0);
        tick(1);
        set_in(1'h0, 1'h0, 1'h0);
        tick(3);
        chk(alert_n, 1'h0);
        tick(1);
        set_in(1'h1, 1'h0, 1'h0);
        tick(3);
        chk(gate_on, 1'h1);
        chk(alert_n, 1'h1);
        $display("test overcurrent done");
    endtask

    task automatic t_short();
        tick(1);
        set_in(1'h1, 1'h1, 1'h1);
        tick(3);
        chk(slow_off, 1'h1);
        chk(gate_on, 1'h0);
        chk(alert_n, 1'h0);
        repeat (2)
        begin
            tick(1);
            set_in(1'h0, 1'h0, 1'h0);
            tick(SC_CYC - 10);
            set_in(1'h1, 1'h0, 1'h0);
            tick(3);
            chk(slow_off, 1'h1);
            chk(gate_on, 1'h0);
        end
        tick(1);
        set_in(1'h0, 1'h0, 1'h0);
        tick(SC_CYC + 4);
        chk(slow_off, 1'h0);
        chk(alert_n, 1'h1);
        tick(1);
        set_in(1'h1, 1'h0, 1'h0);
        tick(3);
        chk(gate_on, 1'h1);
        $display("test short done");
    endtask

    task automatic t_freq();
        tick(1);
        set_in(1'h0, 1'h0, 1'h0);
        tick(300);
        chk(conv_high, 1'h0);
        tick(1);
        run <= 1'h1;
        tick(300);
        chk(conv_high, 1'h0);
        tick(1);
        period <= 16'h012c;
        tick(320);
        period <= 16'h0064;
        tick(320);
        chk(conv_high, 1'h0);
        tick(900);
        chk(conv_high, 1'h1);
        tick(1);
        period <= 16'h0190;
        tick(1200);
        chk(conv_high, 1'h1);
        tick(1);
        run <= 1'h0;
        // power removal clears the high peak limit
        rst_n <= 1'h0;
        tick(2);
        rst_n <= 1'h1;
        tick(2);
        chk(conv_high, 1'h0);
        $display("test frequency done");
    endtask

    task automatic t_conv();
        tick(1);
        rail <= 1'h1;
        tick(2);
        chk(conv_on, 1'h1);
        tick(1);
        peak <= 1'h1;
        tick(2);
        chk(conv_on, 1'h0);
        tick(1);
        peak <= 1'h0;
        zero <= 1'h1;
        tick(2);
        chk(conv_on, 1'h1);
        tick(1);
        peak <= 1'h1;
        rail <= 1'h0;
        tick(4);
        chk(conv_on, 1'h0);
        tick(1);
        peak <= 1'h0;
        tick(3);
        chk(conv_on, 1'h0);
        $display("test converter done");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(8);
        chk(alert_n, 1'h0);
        chk(gate_on, 1'h0);
        tick(1);
        rst_n <= 1'h1;
        t_ready();
        t_overcurrent();
        t_short();
        t_freq();
        t_conv();
        stop_test();
    end
endmodule
`default_nettype wire
